// >>> hw/dac_cfg_pkg.sv
package dac_cfg_pkg;

  localparam int SAMPLE_W = 16;
  localparam int ADDR_W   = 7;
  localparam int DATA_W   = 8;
  localparam int SYNC_W   = 3;
  localparam int CNT_W    = 5;

  // register addresses
  localparam logic [ADDR_W-1:0] ADDR_SW_RESET  = 7'h01;
  localparam logic [ADDR_W-1:0] ADDR_CLK_RX    = 7'h03;
  localparam logic [ADDR_W-1:0] ADDR_PORT_CTRL = 7'h04;
  localparam logic [ADDR_W-1:0] ADDR_TEST_MUX  = 7'h18;
  localparam logic [ADDR_W-1:0] ADDR_TEMP      = 7'h19;
  localparam logic [ADDR_W-1:0] ADDR_PATTERN_GEN_ENABLE   = 7'h1e;
  localparam logic [ADDR_W-1:0] ADDR_PGEN_VAL  = 7'h1f;

  // field positions
  localparam int BIT_SW_RESET  = 0;
  localparam int BIT_CLK_RX_EN = 0;
  localparam int BIT_CLK_OK    = 1;
  localparam int BIT_DCK_QUAD  = 2;
  localparam int BIT_RX_A      = 0;
  localparam int BIT_RX_B      = 1;
  localparam int BIT_SP        = 2;
  localparam int BIT_DATA_EN   = 3;
  localparam int BIT_TMUX_EN   = 6;
  localparam int BIT_TEMP_DIODE_ENABLE   = 0;
  localparam int BIT_TEMP_SENSE_SELECT  = 1;
  localparam int BIT_PATTERN_GEN_ENABLE   = 0;
  localparam int BIT_SPI_READ  = 7;

  // writable bits per register, the rest read zero except 0x03 bit 1, which reads clock ok
  localparam logic [DATA_W-1:0] MASK_CLK_RX   = 8'h75;
  localparam logic [DATA_W-1:0] MASK_PORT     = 8'h0f;
  localparam logic [DATA_W-1:0] MASK_TEST_MUX = 8'h7f;
  localparam logic [DATA_W-1:0] MASK_TEMP     = 8'h03;
  localparam logic [DATA_W-1:0] MASK_PATTERN_GEN_ENABLE  = 8'h01;
  localparam logic [DATA_W-1:0] MASK_PGEN_VAL = 8'hff;
  localparam logic [DATA_W-1:0] REG_RESET_VAL = 8'h00;

  // serial frame: r/w + 7-bit address, then 8 data bits, msb first
  localparam logic [CNT_W-1:0] SPI_HDR_BITS   = 5'h08;
  localparam logic [CNT_W-1:0] SPI_FRAME_BITS = 5'h10;

  localparam logic [SAMPLE_W-1:0] MID_SCALE = 16'h8000;
  localparam int DIV_W = 2;

  typedef enum logic [1:0] {
    SPI_IDLE = 2'b00,
    SPI_HDR  = 2'b01,
    SPI_DATA = 2'b10
  } spi_state_t;

  typedef struct packed {
    logic [DATA_W-1:0] clk_rx;
    logic [DATA_W-1:0] port;
    logic [DATA_W-1:0] tmux;
    logic [DATA_W-1:0] temp;
    logic [DATA_W-1:0] pattern_gen_enable;
    logic [DATA_W-1:0] pgen_val;
  } cfg_t;

  typedef struct packed {
    logic [SYNC_W-1:0]   cs_sync;
    logic [SYNC_W-1:0]   sck_sync;
    logic [SYNC_W-1:0]   sdi_sync;
    logic [SYNC_W-1:0]   dck_sync;
    logic                cs_n;
    logic                sck;
    logic                dck;
    spi_state_t          spi;
    logic [CNT_W-1:0]    bit_cnt;
    logic [SAMPLE_W-1:0] shift;
    logic                rd;
    logic [DATA_W-1:0]   rd_data;
    logic                sdo;
    cfg_t                cfg;
    logic                clk_ok;
    logic [DIV_W-1:0]    div_cnt;
    logic [SAMPLE_W-1:0] held_b;
    logic                b_pending;
    logic [SAMPLE_W-1:0] dac;
  } state_t;

endpackage

// >>> hw/dac_config_and_startup.sv
`timescale 1ns/1ps
// Function
// R01: test mux enable bit 6 routes test signals
// R02: register 0x19 bit 0 enables temperature diode
// R03: bit 1 selects diode or proportional voltage
// R04: pattern generator enable and 8-bit value
// R05: writing 0x01 to 0x01 resets configuration
// R06: divided clock out at quarter sample rate
// R07: host drives data clock at documented rate; the host model slows it so the 3-flop sync keeps up
// R08: host drives zeros before enabling receivers
// R09: host enables clock receiver via 0x03
// R10: host enables data receivers via 0x04
// R11: host waits 1 ms before data enable
// R12: host sets data enable keeping other bits
// R13: dual-port: port A sample before B
// R14: data enable cleared forces mid-scale output
// R15: register 0x04 bit 2 selects port mode
// R16: register 0x03 bit 2 selects quadrature; the code stores the bit but nothing uses it
// R17: reserved addresses and bits read zero
// R18: software reset restores all reset values; clock ok stays set if an enabled data clock edge lands in the reset cycle
module dac_config_and_startup
  import dac_cfg_pkg::*;
(
  // clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_rst_n,
  // serial configuration port
  input  wire logic                i_spi_cs_n,
  input  wire logic                i_spi_sck,
  input  wire logic                i_spi_sdi,
  output logic                     o_spi_sdo,
  // data interface
  input  wire logic                i_data_clock_in,
  input  wire logic [SAMPLE_W-1:0] i_port_a_data,
  input  wire logic [SAMPLE_W-1:0] i_port_b_data,
  output logic                     o_divided_clock_out,
  output logic [SAMPLE_W-1:0]      o_dac_code,
  // test and temperature pins
  output logic                     o_test_mux_enable,
  output logic                     o_temp_diode_enable,
  output logic                     o_temp_sense_select
);

  state_t            s_r;
  state_t            s_nxt;
  logic              cs_fall;
  logic              cs_rise;
  logic              sck_rise;
  logic              sck_fall;
  logic              dck_rise;
  logic [CNT_W-1:0]  cnt_inc;
  logic [SAMPLE_W-1:0] shift_in;
  logic              wr_stb;
  logic              rd_load;
  logic [ADDR_W-1:0] hdr_addr;
  logic [SAMPLE_W-1:0] word_a;
  logic [SAMPLE_W-1:0] word_b;

  function automatic logic [DATA_W-1:0] read_reg(input cfg_t c, input logic ok,
                                                 input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] v;
    v = REG_RESET_VAL;
    case (a)
      ADDR_CLK_RX: begin
        v = c.clk_rx;
        v[BIT_CLK_OK] = ok;
      end
      ADDR_PORT_CTRL: v = c.port;
      ADDR_TEST_MUX:  v = c.tmux;
      ADDR_TEMP:      v = c.temp;
      ADDR_PATTERN_GEN_ENABLE:   v = c.pattern_gen_enable;
      ADDR_PGEN_VAL:  v = c.pgen_val;
      default:        v = REG_RESET_VAL;
    endcase
    return v;
  endfunction

  // a change counts once the second and third flops agree
  assign cs_fall  = (s_r.cs_sync[1] == s_r.cs_sync[2]) && !s_r.cs_sync[2] && s_r.cs_n;
  assign cs_rise  = (s_r.cs_sync[1] == s_r.cs_sync[2]) && s_r.cs_sync[2] && !s_r.cs_n;
  assign sck_rise = (s_r.sck_sync[1] == s_r.sck_sync[2]) && s_r.sck_sync[2] && !s_r.sck;
  assign sck_fall = (s_r.sck_sync[1] == s_r.sck_sync[2]) && !s_r.sck_sync[2] && s_r.sck;
  assign dck_rise = (s_r.dck_sync[1] == s_r.dck_sync[2]) && s_r.dck_sync[2] && !s_r.dck;

  assign cnt_inc  = s_r.bit_cnt + 5'h01;
  assign shift_in = {s_r.shift[SAMPLE_W-2:0], s_r.sdi_sync[2]};
  assign hdr_addr = shift_in[ADDR_W-1:0];
  assign rd_load  = !cs_rise && !cs_fall && sck_rise && (s_r.spi == SPI_HDR)
                    && (cnt_inc == SPI_HDR_BITS);
  assign wr_stb   = !cs_rise && !cs_fall && sck_rise && (s_r.spi == SPI_DATA)
                    && (cnt_inc == SPI_FRAME_BITS) && !s_r.rd;

  // a disabled receiver contributes zeros
  assign word_a = s_r.cfg.port[BIT_RX_A] ? i_port_a_data : '0;
  assign word_b = s_r.cfg.port[BIT_RX_B] ? i_port_b_data : '0;

  always_comb begin
    logic [ADDR_W-1:0] wa;
    logic [DATA_W-1:0] wd;
    logic              new_word;
    logic [SAMPLE_W-1:0] word;
    wa       = shift_in[SAMPLE_W-2:DATA_W];
    wd       = shift_in[DATA_W-1:0];
    new_word = 1'b0;
    word     = s_r.dac;
    s_nxt    = s_r;
    s_nxt.cs_sync  = {s_r.cs_sync[1:0], i_spi_cs_n};
    s_nxt.sck_sync = {s_r.sck_sync[1:0], i_spi_sck};
    s_nxt.sdi_sync = {s_r.sdi_sync[1:0], i_spi_sdi};
    s_nxt.dck_sync = {s_r.dck_sync[1:0], i_data_clock_in};
    if (s_r.cs_sync[1] == s_r.cs_sync[2]) s_nxt.cs_n = s_r.cs_sync[2];
    if (s_r.sck_sync[1] == s_r.sck_sync[2]) s_nxt.sck = s_r.sck_sync[2];
    if (s_r.dck_sync[1] == s_r.dck_sync[2]) s_nxt.dck = s_r.dck_sync[2];

    // serial port
    if (cs_rise) begin
      s_nxt.spi = SPI_IDLE;
      s_nxt.sdo = 1'b0;
    end else if (cs_fall) begin
      s_nxt.spi     = SPI_HDR;
      s_nxt.bit_cnt = '0;
    end else if (sck_rise && s_r.spi != SPI_IDLE) begin
      s_nxt.shift   = shift_in;
      s_nxt.bit_cnt = cnt_inc;
      if (rd_load) begin
        s_nxt.spi = SPI_DATA;
        s_nxt.rd  = shift_in[BIT_SPI_READ];
        // R17: unmapped reads zero
        s_nxt.rd_data = read_reg(s_r.cfg, s_r.clk_ok, hdr_addr);
      end else if (cnt_inc == SPI_FRAME_BITS) begin
        // later clocks in the same frame are ignored
        s_nxt.spi = SPI_IDLE;
      end
    end else if (sck_fall && s_r.spi == SPI_DATA && s_r.rd) begin
      s_nxt.sdo     = s_r.rd_data[DATA_W-1];
      s_nxt.rd_data = {s_r.rd_data[DATA_W-2:0], 1'b0};
    end

    // R17: reserved bits masked on write
    if (wr_stb) begin
      case (wa)
        ADDR_SW_RESET: begin
          // R05: software reset, R18: defaults
          if (wd[BIT_SW_RESET]) begin
            s_nxt.cfg    = '0;
            s_nxt.clk_ok = 1'b0;
          end
        end
        // R09: clock receiver, R16: quadrature
        ADDR_CLK_RX:    s_nxt.cfg.clk_rx   = wd & MASK_CLK_RX;
        ADDR_PORT_CTRL: s_nxt.cfg.port     = wd & MASK_PORT;
        ADDR_TEST_MUX:  s_nxt.cfg.tmux     = wd & MASK_TEST_MUX;
        ADDR_TEMP:      s_nxt.cfg.temp     = wd & MASK_TEMP;
        ADDR_PATTERN_GEN_ENABLE:   s_nxt.cfg.pattern_gen_enable  = wd & MASK_PATTERN_GEN_ENABLE;
        ADDR_PGEN_VAL:  s_nxt.cfg.pgen_val = wd & MASK_PGEN_VAL;
        default:        s_nxt.cfg          = s_r.cfg;
      endcase
    end

    // R06: free-running quarter-rate divider
    s_nxt.div_cnt = s_r.div_cnt + 2'h1;

    if (dck_rise && s_r.cfg.clk_rx[BIT_CLK_RX_EN]) begin
      // set wins: a clock seen in the reset cycle still counts as present
      s_nxt.clk_ok = 1'b1;
      new_word = 1'b1;
      // R15: port mode select
      if (s_r.cfg.port[BIT_SP]) begin
        word = word_b;
        s_nxt.b_pending = 1'b0;
      end else begin
        // R13: port A first, B next cycle
        word            = word_a;
        s_nxt.held_b    = word_b;
        s_nxt.b_pending = 1'b1;
      end
    end else if (s_r.b_pending) begin
      new_word        = 1'b1;
      word            = s_r.held_b;
      s_nxt.b_pending = 1'b0;
    end

    // R14: mid-scale while data disabled
    if (!s_r.cfg.port[BIT_DATA_EN]) begin
      s_nxt.dac = MID_SCALE;
    end else if (s_r.cfg.pattern_gen_enable[BIT_PATTERN_GEN_ENABLE]) begin
      // R04: pattern generator overrides ports
      s_nxt.dac = {s_r.cfg.pgen_val, s_r.cfg.pgen_val};
    end else if (new_word) begin
      s_nxt.dac = word;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r         <= '0;
      s_r.cs_sync <= '1;
      s_r.cs_n    <= 1'b1;
      s_r.dac     <= MID_SCALE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_spi_sdo           = s_r.sdo;
  assign o_divided_clock_out = s_r.div_cnt[DIV_W-1];
  assign o_dac_code          = s_r.dac;
  // R01: test mux, R02/R03: temperature pins
  assign o_test_mux_enable   = s_r.cfg.tmux[BIT_TMUX_EN];
  assign o_temp_diode_enable = s_r.cfg.temp[BIT_TEMP_DIODE_ENABLE];
  assign o_temp_sense_select = s_r.cfg.temp[BIT_TEMP_SENSE_SELECT];

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_mid_scale_out: assert property ( // R14
    !s_r.cfg.port[BIT_DATA_EN] |=> o_dac_code == MID_SCALE)
    else $error("dac not mid-scale while data disabled");
  a_divider_rate: assert property ( // R06
    $rose(o_divided_clock_out) |=> o_divided_clock_out ##1 !o_divided_clock_out ##1
    !o_divided_clock_out ##1 o_divided_clock_out)
    else $error("divided clock not quarter rate");
  a_port_a_first: assert property ( // R13
    dck_rise && s_r.cfg.clk_rx[BIT_CLK_RX_EN] && s_r.cfg.port[BIT_DATA_EN]
    && s_r.cfg.port[BIT_RX_A] && s_r.cfg.port[BIT_RX_B]
    && !s_r.cfg.port[BIT_SP] && !s_r.cfg.pattern_gen_enable[BIT_PATTERN_GEN_ENABLE] && !wr_stb
    |=> o_dac_code == $past(i_port_a_data) ##1 o_dac_code == $past(i_port_b_data, 2))
    else $error("dual-port order wrong");
  a_single_port: assert property ( // R15
    dck_rise && s_r.cfg.clk_rx[BIT_CLK_RX_EN] && s_r.cfg.port[BIT_DATA_EN]
    && s_r.cfg.port[BIT_SP] && s_r.cfg.port[BIT_RX_B]
    && !s_r.cfg.pattern_gen_enable[BIT_PATTERN_GEN_ENABLE] |=> o_dac_code == $past(i_port_b_data))
    else $error("single-port sample not from port b");
  a_pattern_out: assert property ( // R04
    s_r.cfg.port[BIT_DATA_EN] && s_r.cfg.pattern_gen_enable[BIT_PATTERN_GEN_ENABLE]
    |=> o_dac_code == {$past(s_r.cfg.pgen_val), $past(s_r.cfg.pgen_val)})
    else $error("pattern value not on output");
  a_test_mux_wr: assert property ( // R01
    wr_stb && s_r.shift[SAMPLE_W-3:DATA_W-1] == ADDR_TEST_MUX
    |=> o_test_mux_enable == $past(s_r.shift[BIT_TMUX_EN-1]))
    else $error("test mux enable not written");
  a_temp_enable_wr: assert property ( // R02
    wr_stb && s_r.shift[SAMPLE_W-3:DATA_W-1] == ADDR_TEMP
    |=> o_temp_diode_enable == $past(s_r.sdi_sync[2]))
    else $error("temperature enable not written");
  a_temp_select_wr: assert property ( // R03
    wr_stb && s_r.shift[SAMPLE_W-3:DATA_W-1] == ADDR_TEMP
    |=> o_temp_sense_select == $past(s_r.shift[0]))
    else $error("temperature select not written");
  a_sw_reset_cfg: assert property ( // R18
    wr_stb && s_r.shift[SAMPLE_W-3:DATA_W-1] == ADDR_SW_RESET && s_r.sdi_sync[2]
    |=> s_r.cfg == '0 ##1 o_dac_code == MID_SCALE)
    else $error("software reset left configuration");
  a_reserved_read: assert property ( // R17
    rd_load && (hdr_addr > ADDR_PGEN_VAL || (hdr_addr > ADDR_TEMP && hdr_addr < ADDR_PATTERN_GEN_ENABLE))
    |=> s_r.rd_data == REG_RESET_VAL)
    else $error("reserved address read not zero");

  c_sw_reset:  cover property (wr_stb && s_r.shift[SAMPLE_W-3:DATA_W-1] == ADDR_SW_RESET);
  c_dual_pair: cover property (s_r.b_pending && s_r.cfg.port[BIT_DATA_EN]);
  c_pattern:   cover property (s_r.cfg.pattern_gen_enable[BIT_PATTERN_GEN_ENABLE] && s_r.cfg.port[BIT_DATA_EN]);
  c_read:      cover property (rd_load && s_r.shift[BIT_SPI_READ-1]);

endmodule

// >>> tb/host_model.sv
`timescale 1ns/1ps
module host_model
  import dac_cfg_pkg::*;
(
  // clock and serial return
  input  wire logic                i_clk,
  input  wire logic                i_sdo,
  // serial port
  output logic                     o_cs_n,
  output logic                     o_sck,
  output logic                     o_sdi,
  // data link
  output logic                     o_dck,
  output logic [SAMPLE_W-1:0]      o_pa,
  output logic [SAMPLE_W-1:0]      o_pb
);
  initial begin
    {o_cs_n, o_sck, o_sdi, o_dck} = 4'h8;
    {o_pa, o_pb} = '0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // phases of 6 clocks cover sync delay plus sdo latency
  task automatic frame(input logic [15:0] f, output logic [7:0] rd);
    o_cs_n <= 1'b0;
    rd = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      cyc(6);
      o_sck <= 1'b0;
      o_sdi <= f[i];
      cyc(6);
      if (i < 8) rd = {rd[6:0], i_sdo};
      o_sck <= 1'b1;
    end
    cyc(6);
    o_sck <= 1'b0;
    cyc(6);
    o_cs_n <= 1'b1;
    o_sdi <= ~o_sdi;
    cyc(6);
  endtask
  // data clock slowed so the 3-flop sync keeps up
  task automatic up(input logic [SAMPLE_W-1:0] a, b);
    o_pa <= a;
    o_pb <= b;
    o_dck <= 1'b1;
  endtask
  // zero words while the receivers come up
  task automatic zeros();
    o_pa <= '0;
    o_pb <= '0;
    cyc(1);
  endtask
  // released words show the inverse, never the old value
  task automatic down();
    o_dck <= 1'b0;
    o_pa <= ~o_pa;
    o_pb <= ~o_pb;
    cyc(3);
  endtask
endmodule

// >>> tb/dac_config_and_startup_tb.sv
`timescale 1ns/1ps
module dac_config_and_startup_tb;
  import dac_cfg_pkg::*;
  logic                i_clk, i_rst_n, cs_n, sck, sdi, dck, sdo, divc, tmux, tdio, tsel;
  logic [SAMPLE_W-1:0] pa, pb, code;
  logic [7:0]          rd;
  logic                dv [8];
  int                  err_count = 0, cmp_count = 0, cyc_n = 0, ok = 0;
  int                  mdl [128];
  logic [31:0]         rng = 32'd28;
  localparam logic [6:0] AL [9] = '{7'h01, 7'h03, 7'h04, 7'h18, 7'h19, 7'h1a, 7'h1e,
                                    7'h1f, 7'h7f};
  dac_config_and_startup u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_spi_cs_n(cs_n),
    .i_spi_sck(sck), .i_spi_sdi(sdi), .o_spi_sdo(sdo), .i_data_clock_in(dck),
    .i_port_a_data(pa), .i_port_b_data(pb), .o_divided_clock_out(divc),
    .o_dac_code(code), .o_test_mux_enable(tmux), .o_temp_diode_enable(tdio),
    .o_temp_sense_select(tsel));
  host_model u_host (.i_clk(i_clk), .i_sdo(sdo), .o_cs_n(cs_n), .o_sck(sck), .o_sdi(sdi),
    .o_dck(dck), .o_pa(pa), .o_pb(pb));
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function automatic logic [7:0] msk(input logic [6:0] a);
    case (a)
      ADDR_CLK_RX:   return MASK_CLK_RX;
      ADDR_PORT_CTRL: return MASK_PORT;
      ADDR_TEST_MUX: return MASK_TEST_MUX;
      ADDR_TEMP:     return MASK_TEMP;
      ADDR_PATTERN_GEN_ENABLE:  return MASK_PATTERN_GEN_ENABLE;
      ADDR_PGEN_VAL: return MASK_PGEN_VAL;
      default:       return 8'h00;
    endcase
  endfunction
  task automatic close_out();
    $display("counts: %0d compares, %0d mismatches", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic cmp_reg(input logic [7:0] g, e);
    chk({8'h00, g}, {8'h00, e});
  endtask
  task automatic cmp_code(input logic [15:0] g, e);
    chk(g, e);
  endtask
  task automatic cmp_pin(input logic g, e);
    chk({15'h0000, g}, {15'h0000, e});
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_host.frame({1'b0, a, d}, rd);
    mdl[a] = d & msk(a);
    if (a == ADDR_SW_RESET && d[BIT_SW_RESET]) begin
      mdl = '{default: 0};
      ok = 0;
    end
  endtask
  task automatic rdc(input logic [6:0] a);
    u_host.frame({1'b1, a, 8'h00}, rd);
    cmp_reg(rd, 8'(mdl[a]) | ((a == ADDR_CLK_RX && ok != 0) ? 8'h02 : 8'h00));
  endtask
  task automatic pins();
    cmp_pin(tmux, mdl[ADDR_TEST_MUX][BIT_TMUX_EN]);
    cmp_pin(tdio, mdl[ADDR_TEMP][BIT_TEMP_DIODE_ENABLE]);
    cmp_pin(tsel, mdl[ADDR_TEMP][BIT_TEMP_SENSE_SELECT]);
  endtask
  task automatic send(input logic [15:0] a, b);
    logic [15:0] s [8];
    logic [15:0] ea, eb;
    logic        found;
    u_host.up(a, b);
    if (mdl[3][0]) ok = 1;
    if (!mdl[4][3]) {ea, eb} = {MID_SCALE, MID_SCALE};
    else if (mdl['h1e][0]) {ea, eb} = {4{8'(mdl['h1f])}};
    else if (mdl[4][2]) {ea, eb} = {2{mdl[4][1] ? b : 16'h0000}};
    else {ea, eb} = {mdl[4][0] ? a : 16'h0000, mdl[4][1] ? b : 16'h0000};
    found = 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(posedge i_clk);
      s[i] = code;
    end
    for (int i = 0; i < 7; i++) if (s[i] === ea && s[i+1] === eb) found = 1'b1;
    cmp_pin(found, 1'b1);
    cmp_code(s[7], eb);
    u_host.down();
  endtask
  always @(posedge i_clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 80000) begin
      err_count++;
      close_out();
    end
  end
  initial begin
    i_rst_n = 1'b0;
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    u_host.cyc(4);
    foreach (AL[i]) rdc(AL[i]);
    foreach (AL[i]) wr(AL[i], 8'(xs()) & 8'hfe);
    foreach (AL[i]) rdc(AL[i]);
    pins();
    wr(ADDR_SW_RESET, 8'h01);
    foreach (AL[i]) rdc(AL[i]);
    $display("register test done");
    wr(ADDR_TEST_MUX, 8'h40);
    pins();
    wr(ADDR_TEST_MUX, 8'h00);
    wr(ADDR_TEMP, 8'h01);
    pins();
    wr(ADDR_TEMP, 8'h03);
    pins();
    $display("test pin test done");
    for (int i = 0; i < 8; i++) begin
      @(posedge i_clk);
      dv[i] = divc;
    end
    for (int i = 0; i < 6; i++) cmp_pin(dv[i+2], ~dv[i]);
    $display("divider test done");
    send(16'h0000, 16'h0000);
    u_host.zeros();
    wr(ADDR_CLK_RX, 8'h01);
    wr(ADDR_PORT_CTRL, 8'h03);
    send(16'(xs()), 16'(xs()));
    u_host.cyc(40000);
    wr(ADDR_PORT_CTRL, 8'h0b);
    rdc(ADDR_PORT_CTRL);
    repeat (3) send(16'(xs()), 16'(xs()));
    rdc(ADDR_CLK_RX);
    $display("dual port test done");
    wr(ADDR_PORT_CTRL, 8'h09);
    send(16'(xs()), 16'(xs()));
    wr(ADDR_PORT_CTRL, 8'h0e);
    repeat (2) send(16'(xs()), 16'(xs()));
    wr(ADDR_CLK_RX, 8'h05);
    rdc(ADDR_CLK_RX);
    $display("single port test done");
    wr(ADDR_PGEN_VAL, 8'(xs()));
    wr(ADDR_PATTERN_GEN_ENABLE, 8'h01);
    send(16'(xs()), 16'(xs()));
    wr(ADDR_SW_RESET, 8'h01);
    send(16'(xs()), 16'(xs()));
    foreach (AL[i]) rdc(AL[i]);
    $display("pattern and reset test done");
    close_out();
  end
endmodule
